// file: src/async_serial_transceiver.sv
// async serial transceiver: tx, rx, two-entry rx fifo, compare, interrupt source
// assumes rx pin is asynchronous; software keeps its own rules
`timescale 1ns/1ps
module async_serial_transceiver #(
    parameter int unsigned BAUD_W = uart_pkg::BAUD_W
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // module control
    input  wire logic        i_module_enable,
    input  wire logic [7:0]  i_baud_divisor_low,
    input  wire logic        i_baud_divisor_low_we,
    input  wire logic [4:0]  i_baud_divisor_high,
    input  wire logic        i_baud_divisor_high_we,
    input  wire logic [3:0]  i_format,
    input  wire logic        i_format_we,
    input  wire logic [7:0]  i_rx_compare_value,
    input  wire logic        i_rx_compare_we,
    input  wire logic [2:0]  i_irq_mask,
    input  wire logic        i_irq_mask_we,
    // data register
    input  wire logic [7:0]  i_tx_data,
    input  wire logic        i_tx_data_we,
    input  wire logic        i_rx_data_rd,
    // serial pins
    input  wire logic        i_rx,
    output logic             o_tx,
    // status
    output logic [7:0]       o_rx_data,
    output logic             o_rx_parity_err,
    output logic             o_rx_frame_err,
    output logic             o_rx_break,
    output logic             o_fifo_empty,
    output logic             o_fifo_full,
    output logic             o_fifo_overrun_flag,
    output logic             o_transmitter_active,
    output logic             o_receiver_active,
    output logic [2:0]       o_irq_flag_reg,
    output logic             o_irq_source
);
    typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_DONE = 3'b100} tx_state_e;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_BITS = 3'b010, RX_BREAK = 3'b100} rx_state_e;

    logic [BAUD_W-1:0] baud_q;
    logic [3:0]        cfg_q;
    logic [7:0]        cmp_q;
    logic [2:0]        mask_q;
    logic              tick;
    logic              en;
    assign en = i_module_enable;

    // configuration, reset while in standby
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            baud_q <= uart_pkg::BAUD_RESET;
            cfg_q  <= uart_pkg::CFG_RESET;
            cmp_q  <= uart_pkg::BYTE_RESET;
            mask_q <= uart_pkg::MASK_RESET;
        end else if (!en) begin
            baud_q <= uart_pkg::BAUD_RESET;
            cfg_q  <= uart_pkg::CFG_RESET;
            cmp_q  <= uart_pkg::BYTE_RESET;
            mask_q <= uart_pkg::MASK_RESET;
        end else begin
            // two byte loads form the 13-bit divisor
            if (i_baud_divisor_low_we) baud_q[7:0] <= i_baud_divisor_low;
            if (i_baud_divisor_high_we) baud_q[BAUD_W-1:8] <= i_baud_divisor_high;
            if (i_format_we) cfg_q <= i_format;
            if (i_rx_compare_we) cmp_q <= i_rx_compare_value;
            if (i_irq_mask_we) mask_q <= i_irq_mask;
        end
    end

    baud_tick #(.W(BAUD_W)) u_baud (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_enable  (en),
        .i_divisor (baud_q),
        .o_tick    (tick)
    );

    // frame geometry
    logic [3:0] data_bits;
    assign data_bits = cfg_q[uart_pkg::CFG_LEN] ? uart_pkg::DATA8 : uart_pkg::DATA7;

    // transmitter
    tx_state_e  tx_st_q;
    logic [11:0] tx_sh_q;
    logic [3:0]  tx_left_q;
    logic [2:0]  tx_smp_q;
    logic        tx_end;
    logic        tx_par;
    assign tx_par = ^(i_tx_data & (cfg_q[uart_pkg::CFG_LEN] ? 8'hff : 8'h7f)) ^ cfg_q[uart_pkg::CFG_ODD];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_st_q   <= TX_IDLE;
            tx_sh_q   <= '1;
            tx_left_q <= '0;
            tx_smp_q  <= '0;
        end else if (!en) begin
            tx_st_q   <= TX_IDLE;
            tx_sh_q   <= '1;
            tx_left_q <= '0;
            tx_smp_q  <= '0;
        end else begin
            case (tx_st_q)
                TX_IDLE, TX_DONE: begin
                    tx_st_q <= TX_IDLE;
                    if (i_tx_data_we) begin
                        // load and start at once
                        tx_st_q <= TX_SEND;
                        tx_smp_q <= '0;
                        // stops idle, start opposite, parity completes ones
                        if (cfg_q[uart_pkg::CFG_LEN]) begin
                            tx_sh_q <= {2'b11, cfg_q[uart_pkg::CFG_PAR] ? tx_par : uart_pkg::LINE_IDLE,
                                        i_tx_data, uart_pkg::LINE_START};
                        end else begin
                            tx_sh_q <= {3'b111, cfg_q[uart_pkg::CFG_PAR] ? tx_par : uart_pkg::LINE_IDLE,
                                        i_tx_data[6:0], uart_pkg::LINE_START};
                        end
                        tx_left_q <= 4'(1 + data_bits + 4'(cfg_q[uart_pkg::CFG_PAR])
                                        + 4'(cfg_q[uart_pkg::CFG_STPB]) + 1);
                    end
                end
                TX_SEND: begin
                    if (tick) begin
                        tx_smp_q <= tx_smp_q + 1'b1;
                        // eight ticks per bit
                        if (tx_smp_q == uart_pkg::SAMPLE_LAST) begin
                            tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
                            tx_left_q <= tx_left_q - 1'b1;
                            if (tx_left_q == 4'h1) tx_st_q <= TX_DONE;
                        end
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end
    assign tx_end = (tx_st_q == TX_DONE);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) o_tx <= uart_pkg::LINE_IDLE;
        else o_tx <= (en && tx_st_q == TX_SEND) ? tx_sh_q[0] : uart_pkg::LINE_IDLE;
    end
    assign o_transmitter_active = (tx_st_q == TX_SEND);

    // rx synchroniser and majority filter
    logic [1:0] rx_sync_q;
    logic [1:0] rx_hist_q;
    logic       rx_filt_q;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_sync_q <= 2'b11;
            rx_hist_q <= 2'b11;
            rx_filt_q <= uart_pkg::LINE_IDLE;
        end else begin
            rx_sync_q <= {rx_sync_q[0], i_rx};
            if (!en) begin
                rx_hist_q <= 2'b11;
                rx_filt_q <= uart_pkg::LINE_IDLE;
            end else if (tick) begin
                rx_hist_q <= {rx_hist_q[0], rx_sync_q[1]};
                rx_filt_q <= (rx_hist_q[0] & rx_hist_q[1]) | (rx_hist_q[0] & rx_sync_q[1])
                           | (rx_hist_q[1] & rx_sync_q[1]);
            end
        end
    end

    // receiver
    rx_state_e  rx_st_q;
    logic [2:0] rx_smp_q;
    logic [3:0] rx_idx_q;
    logic [7:0] rx_sh_q;
    logic       rx_perr_q;
    logic       rx_ferr_q;
    logic       rx_low_q;
    logic       rx_filt_d1_q;
    logic       rx_done;
    logic       rx_brk;
    logic [3:0] rx_total;
    logic       bit_pick;
    assign rx_total = 4'(1 + data_bits + 4'(cfg_q[uart_pkg::CFG_PAR]) + 4'(cfg_q[uart_pkg::CFG_STPB]) + 1);
    assign bit_pick = tick && (rx_smp_q == uart_pkg::SAMPLE_PICK);
    assign rx_done  = (rx_st_q == RX_BITS) && bit_pick && (rx_idx_q == rx_total - 1'b1);
    assign rx_brk   = rx_done && rx_low_q && !rx_filt_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_st_q <= RX_IDLE;
            rx_smp_q <= '0;
            rx_idx_q <= '0;
            rx_sh_q <= '0;
            rx_perr_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_low_q <= 1'b0;
            rx_filt_d1_q <= uart_pkg::LINE_IDLE;
        end else if (!en) begin
            rx_st_q <= RX_IDLE;
            rx_smp_q <= '0;
            rx_idx_q <= '0;
            rx_sh_q <= '0;
            rx_perr_q <= 1'b0;
            rx_ferr_q <= 1'b0;
            rx_low_q <= 1'b0;
            rx_filt_d1_q <= uart_pkg::LINE_IDLE;
        end else if (tick) begin
            rx_filt_d1_q <= rx_filt_q;
            rx_smp_q <= rx_smp_q + 1'b1;
            case (rx_st_q)
                RX_IDLE: begin
                    if (rx_filt_d1_q && !rx_filt_q) begin
                        rx_st_q <= RX_BITS;
                        rx_smp_q <= 3'h1;
                        rx_idx_q <= '0;
                        rx_perr_q <= cfg_q[uart_pkg::CFG_ODD];
                        rx_ferr_q <= 1'b0;
                        rx_low_q <= 1'b1;
                        rx_sh_q <= '0;
                    end
                end
                RX_BITS: begin
                    if (rx_smp_q == uart_pkg::SAMPLE_PICK) begin
                        rx_idx_q <= rx_idx_q + 1'b1;
                        if (rx_filt_q) rx_low_q <= 1'b0;
                        if (rx_idx_q == '0) begin
                            if (rx_filt_q) rx_ferr_q <= 1'b1;
                        end else if (rx_idx_q <= data_bits) begin
                            rx_sh_q[3'(rx_idx_q - 1'b1)] <= rx_filt_q;
                            rx_perr_q <= rx_perr_q ^ rx_filt_q;
                        end else if (cfg_q[uart_pkg::CFG_PAR] && rx_idx_q == data_bits + 1'b1) begin
                            rx_perr_q <= rx_perr_q ^ rx_filt_q;
                        end else if (!rx_filt_q) begin
                            rx_ferr_q <= 1'b1;
                        end
                        if (rx_idx_q == rx_total - 1'b1) begin
                            rx_st_q <= (rx_low_q && !rx_filt_q) ? RX_BREAK : RX_IDLE;
                        end
                    end
                end
                RX_BREAK: begin
                    if (rx_filt_q) rx_st_q <= RX_IDLE;
                end
                default: rx_st_q <= RX_IDLE;
            endcase
        end
    end
    assign o_receiver_active = (rx_st_q == RX_BITS);

    logic perr_now;
    logic ferr_now;
    logic cmp_hit;
    assign perr_now = cfg_q[uart_pkg::CFG_PAR] && rx_perr_q;
    assign ferr_now = rx_ferr_q || !rx_filt_q;
    // compare, not on errored frames
    assign cmp_hit = rx_done && !perr_now && !ferr_now && (rx_sh_q == cmp_q);

    // two-entry fifo
    logic [10:0] fifo_q [uart_pkg::FIFO_DEPTH];
    logic [1:0]  cnt_q;
    logic        ovr_q;
    logic        push;
    logic        pop;
    assign pop  = i_rx_data_rd && (cnt_q != 2'h0);
    assign push = rx_done && ((cnt_q != 2'(uart_pkg::FIFO_DEPTH)) || pop);
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
            cnt_q <= '0;
            ovr_q <= 1'b0;
        end else if (!en) begin
            fifo_q[0] <= '0;
            fifo_q[1] <= '0;
            cnt_q <= '0;
            ovr_q <= 1'b0;
        end else begin
            if (pop) fifo_q[0] <= fifo_q[1];
            if (push) fifo_q[1'(cnt_q - 2'(pop))] <= {rx_brk, ferr_now, perr_now, rx_sh_q};
            cnt_q <= 2'(cnt_q + 2'(push) - 2'(pop));
            // dropped third frame
            if (rx_done && !push) ovr_q <= 1'b1;
        end
    end
    assign {o_rx_break, o_rx_frame_err, o_rx_parity_err, o_rx_data} = fifo_q[0];
    assign o_fifo_empty = (cnt_q == 2'h0);
    assign o_fifo_full  = (cnt_q == 2'(uart_pkg::FIFO_DEPTH));
    assign o_fifo_overrun_flag = ovr_q;

    // flags refreshed per telegram end, kept until next end
    logic [2:0] flag_q;
    logic       frame_received_event_en;
    logic       brk_en;
    logic       adr_en;
    assign frame_received_event_en = rx_done && mask_q[uart_pkg::IRQ_FRAME_RECEIVED_EVENT];
    assign brk_en  = rx_brk && mask_q[uart_pkg::IRQ_BRK];
    assign adr_en  = cmp_hit && mask_q[uart_pkg::IRQ_ADR];
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flag_q <= '0;
        end else if (!en) begin
            flag_q <= '0;
        end else if (rx_done) begin
            flag_q[uart_pkg::IRQ_FRAME_RECEIVED_EVENT] <= frame_received_event_en && (cnt_q == 2'h0);
            flag_q[uart_pkg::IRQ_BRK]  <= brk_en;
            flag_q[uart_pkg::IRQ_ADR]  <= adr_en;
        end
    end
    assign o_irq_flag_reg = flag_q;

    // one pulse per sent telegram, and per received telegram with an unmasked event
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) o_irq_source <= 1'b0;
        else o_irq_source <= en && (tx_end || frame_received_event_en || brk_en || adr_en);
    end
endmodule

// file: src/uart_pkg.sv
// constants for the async serial transceiver
// assumes a single system clock f0 drives the whole block
package uart_pkg;
    localparam int unsigned BAUD_W       = 13;
    localparam int unsigned SAMPLES      = 8;
    localparam int unsigned SAMPLE_W     = 3;
    localparam logic [2:0]  SAMPLE_PICK  = 3'h4;
    localparam logic [2:0]  SAMPLE_LAST  = 3'h7;
    localparam int unsigned BITCNT_W     = 4;
    localparam logic [12:0] BAUD_RESET   = 13'h0000;
    localparam logic [7:0]  BYTE_RESET   = 8'h00;
    localparam logic [3:0]  CFG_RESET    = 4'h0;
    localparam logic [2:0]  MASK_RESET   = 3'h0;
    localparam int unsigned CFG_LEN      = 0;
    localparam int unsigned CFG_PAR      = 1;
    localparam int unsigned CFG_ODD      = 2;
    localparam int unsigned CFG_STPB     = 3;
    localparam int unsigned IRQ_FRAME_RECEIVED_EVENT     = 0;
    localparam int unsigned IRQ_BRK      = 1;
    localparam int unsigned IRQ_ADR      = 2;
    localparam int unsigned FIFO_DEPTH   = 2;
    localparam logic        LINE_IDLE    = 1'b1;
    localparam logic        LINE_START   = 1'b0;
    localparam logic [3:0]  DATA7        = 4'h7;
    localparam logic [3:0]  DATA8        = 4'h8;
endpackage

// file: src/baud_tick.sv
// sample tick generator: 13-bit down-counter
// assumes divisor is stable while enabled
`timescale 1ns/1ps
module baud_tick #(
    parameter int unsigned W = 13
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    // control
    input  wire logic         i_enable,
    input  wire logic [W-1:0] i_divisor,
    // tick out
    output logic              o_tick
);
    logic [W-1:0] count_q;

    // reload n gives f0/(n+1)
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count_q <= '0;
        end else if (!i_enable) begin
            count_q <= '0;
        end else if (count_q == '0) begin
            count_q <= i_divisor;
        end else begin
            count_q <= count_q - 1'b1;
        end
    end

    assign o_tick = i_enable && (count_q == '0);
endmodule

// file: bench/uart_sva.sv
// assertions on the async serial transceiver top-level ports
// assumes one clock i_clk and async active-low reset i_reset_n
`timescale 1ns/1ps
module uart_sva #(
    parameter int unsigned BAUD_W = uart_pkg::BAUD_W
) (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_reset_n,
    // control
    input wire logic       i_module_enable,
    input wire logic       i_tx_data_we,
    // observed outputs
    input wire logic       o_tx,
    input wire logic       o_transmitter_active,
    input wire logic       o_receiver_active,
    input wire logic       o_fifo_empty,
    input wire logic       o_fifo_full,
    input wire logic       o_fifo_overrun_flag,
    input wire logic [2:0] o_irq_flag_reg,
    input wire logic       o_irq_source
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_tx_launch;
        i_module_enable && !o_transmitter_active && i_tx_data_we;
    endsequence
    sequence s_start_out;
        o_transmitter_active ##1 (o_tx == uart_pkg::LINE_START);
    endsequence
    property p_tx_start;
        s_tx_launch |=> s_start_out;
    endproperty
    property p_standby;
        !i_module_enable |=> !o_transmitter_active && !o_receiver_active && o_tx && o_fifo_empty
            && !o_fifo_overrun_flag && (o_irq_flag_reg == 3'h0) && !o_irq_source;
    endproperty
    property p_irq_pulse;
        o_irq_source |=> !o_irq_source;
    endproperty
    property p_tx_end_irq;
        $fell(o_transmitter_active) && i_module_enable && $past(i_module_enable) |-> ##[0:1] o_irq_source;
    endproperty
    property p_idle_tx_high;
        !o_transmitter_active |-> o_tx;
    endproperty
    property p_fifo_excl;
        o_fifo_full |-> !o_fifo_empty;
    endproperty
    property p_overrun_sticky;
        o_fifo_overrun_flag && i_module_enable |=> o_fifo_overrun_flag;
    endproperty
    property p_overrun_needs_full;
        $rose(o_fifo_overrun_flag) |-> $past(o_fifo_full);
    endproperty
    property p_flag_irq;
        (o_irq_flag_reg != $past(o_irq_flag_reg)) && (o_irq_flag_reg != 3'h0) && i_module_enable
            && $past(i_module_enable) |-> ##[0:1] o_irq_source;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("tx start not launched");
    a_standby: assert property (p_standby) else $error("standby not clean");
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
    a_tx_end_irq: assert property (p_tx_end_irq) else $error("no irq at tx end");
    a_idle_tx_high: assert property (p_idle_tx_high) else $error("tx not idle high");
    a_fifo_excl: assert property (p_fifo_excl) else $error("fifo full and empty");
    a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun lost");
    a_overrun_needs_full: assert property (p_overrun_needs_full) else $error("overrun without full");
    a_flag_irq: assert property (p_flag_irq) else $error("flag set without irq");
endmodule

bind async_serial_transceiver uart_sva #(.BAUD_W(BAUD_W)) u_sva (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_module_enable(i_module_enable), .i_tx_data_we(i_tx_data_we),
    .o_tx(o_tx), .o_transmitter_active(o_transmitter_active), .o_receiver_active(o_receiver_active),
    .o_fifo_empty(o_fifo_empty), .o_fifo_full(o_fifo_full), .o_fifo_overrun_flag(o_fifo_overrun_flag),
    .o_irq_flag_reg(o_irq_flag_reg), .o_irq_source(o_irq_source));

// file: bench/serial_peer.sv
// remote serial device driving the receive line
// assumes caller gives start, data, parity and stops lsb first
`timescale 1ns/1ps
module serial_peer (
    // clock
    input  wire logic i_clk,
    // line
    output logic      o_line
);
    initial o_line = 1'b1; // idle high
    task automatic send_bits(input logic [11:0] b, input int bit_clks);
        for (int i = 0; i < 12; i++) begin
            @(negedge i_clk);
            o_line = b[i];
            repeat (bit_clks - 1) @(negedge i_clk); // same rate as receiver
        end
        @(negedge i_clk);
        o_line = 1'b1;
    endtask
endmodule

// file: bench/tb_top.sv
// testbench for the async serial transceiver
// assumes serial_peer on the rx line, inputs driven at falling edge
`timescale 1ns/1ps
module tb_top;
    logic       i_clk = 1'b0, i_reset_n = 1'b0, i_module_enable = 1'b0;
    logic [7:0] i_baud_divisor_low = 8'h00, i_rx_compare_value = 8'h00, i_tx_data = 8'h00;
    logic [4:0] i_baud_divisor_high = 5'h00;
    logic [3:0] i_format = 4'h0;
    logic [2:0] i_irq_mask = 3'h0;
    logic       i_baud_divisor_low_we = 1'b0, i_baud_divisor_high_we = 1'b0, i_format_we = 1'b0;
    logic       i_rx_compare_we = 1'b0, i_irq_mask_we = 1'b0, i_tx_data_we = 1'b0, i_rx_data_rd = 1'b0;
    logic       i_rx, o_tx, o_rx_parity_err, o_rx_frame_err, o_rx_break, o_fifo_empty, o_fifo_full;
    logic       o_fifo_overrun_flag, o_transmitter_active, o_receiver_active, o_irq_source;
    logic [7:0] o_rx_data;
    logic [2:0] o_irq_flag_reg;
    int         miscompares = 0, n_checks = 0, irq_cnt = 0, bitclk = 16;
    always #4 i_clk = ~i_clk;
    always @(negedge i_clk) if (o_irq_source === 1'b1) irq_cnt++;
    serial_peer u_peer (.i_clk, .o_line(i_rx));
    async_serial_transceiver u_dut (.i_clk, .i_reset_n, .i_module_enable, .i_baud_divisor_low,
        .i_baud_divisor_low_we, .i_baud_divisor_high, .i_baud_divisor_high_we, .i_format, .i_format_we,
        .i_rx_compare_value, .i_rx_compare_we, .i_irq_mask, .i_irq_mask_we, .i_tx_data, .i_tx_data_we,
        .i_rx_data_rd, .i_rx, .o_tx, .o_rx_data, .o_rx_parity_err, .o_rx_frame_err, .o_rx_break,
        .o_fifo_empty, .o_fifo_full, .o_fifo_overrun_flag, .o_transmitter_active, .o_receiver_active,
        .o_irq_flag_reg, .o_irq_source);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic set_div(input logic [12:0] d);
        {i_baud_divisor_low, i_baud_divisor_low_we} = {d[7:0], 1'b1};
        step(1);
        i_baud_divisor_low_we = 1'b0;
        {i_baud_divisor_high, i_baud_divisor_high_we} = {d[12:8], 1'b1}; // high last
        step(1);
        i_baud_divisor_high_we = 1'b0;
        bitclk = (int'(d) + 1) * 8;
    endtask
    task automatic cfg(input logic [3:0] f, input logic [7:0] c, input logic [2:0] m);
        {i_format, i_rx_compare_value, i_irq_mask} = {f, c, m};
        {i_format_we, i_rx_compare_we, i_irq_mask_we} = 3'h7;
        step(1);
        {i_format_we, i_rx_compare_we, i_irq_mask_we} = 3'h0;
    endtask
    function automatic logic [11:0] frame(input logic [7:0] d, input logic [3:0] f);
        logic [11:0] b;
        int          n;
        n = f[0] ? 8 : 7;
        b = 12'hffe;
        for (int i = 0; i < n; i++) b[i+1] = d[i];
        if (f[1]) b[n+1] = (f[0] ? ^d : ^d[6:0]) ^ f[2];
        return b;
    endfunction
    task automatic wait_tx(input logic v, output int w);
        w = 0;
        while (o_tx !== v && w < 4000) begin
            step(1);
            w++;
        end
    endtask
    task automatic tx_frame(input logic [3:0] f);
        logic [11:0] s;
        int          w;
        int          n0;
        cfg(f, 8'h00, 3'h0);
        n0 = irq_cnt;
        {i_tx_data, i_tx_data_we} = {8'ha5, 1'b1};
        step(1);
        i_tx_data_we = 1'b0;
        check(o_transmitter_active, 1'b1);
        wait_tx(1'b0, w);
        wait_tx(1'b1, w);
        wait_tx(1'b0, w);
        check(w, bitclk);
        step(bitclk / 2);
        s[1:0] = 2'b10;
        for (int i = 2; i < 12; i++) begin
            s[i] = o_tx;
            step(bitclk);
        end
        check(s, frame(8'ha5, f));
        check({o_transmitter_active, 15'(irq_cnt - n0)}, 16'h0001);
    endtask
    task automatic rx_frame(input logic [11:0] b, input logic [2:0] fl);
        int n0;
        n0 = irq_cnt;
        u_peer.send_bits(b, bitclk);
        step(8);
        check(o_irq_flag_reg, fl);
        check(irq_cnt - n0, 1);
    endtask
    task automatic pop(input logic [7:0] d);
        check(o_rx_data, d);
        i_rx_data_rd = 1'b1;
        step(1);
        i_rx_data_rd = 1'b0;
        step(1);
    endtask
    initial begin
        step(16);
        i_reset_n = 1'b1;
        step(1);
        check({o_tx, o_fifo_empty, o_transmitter_active, o_irq_flag_reg}, 6'h30);
        i_tx_data_we = 1'b1;
        step(1);
        i_tx_data_we = 1'b0;
        step(3);
        check({o_transmitter_active, o_tx}, 2'h1);
        i_module_enable = 1'b1;
        set_div(13'h0002);
        for (int f = 0; f < 16; f++) tx_frame(4'(f));
        set_div(13'h0001);
        cfg(4'h3, 8'h5a, 3'h7);
        rx_frame(frame(8'h5a, 4'h3), 3'h5);
        rx_frame(frame(8'h33, 4'h3), 3'h0);
        rx_frame(frame(8'h5a, 4'h3), 3'h4);
        check({o_fifo_empty, o_fifo_full, o_fifo_overrun_flag}, 3'h3);
        pop(8'h5a);
        pop(8'h33);
        check(o_fifo_empty, 1'b1);
        rx_frame(frame(8'h5a, 4'h3) ^ 12'h200, 3'h1);
        check({o_rx_parity_err, o_rx_frame_err}, 2'h2);
        pop(8'h5a);
        cfg(4'h0, 8'h5a, 3'h7);
        rx_frame(frame(8'h5a, 4'h0), 3'h5);
        pop(8'h5a);
        cfg(4'he, 8'h5a, 3'h7);
        rx_frame(frame(8'h5a, 4'he), 3'h5);
        check({o_rx_parity_err, o_rx_frame_err}, 2'h0);
        pop(8'h5a);
        cfg(4'h3, 8'h5a, 3'h2);
        rx_frame(12'h000, 3'h2);
        check({o_rx_break, o_rx_frame_err, o_rx_parity_err}, 3'h6);
        step(bitclk);
        {i_tx_data, i_tx_data_we} = {8'h0f, 1'b1};
        step(1);
        i_tx_data_we = 1'b0;
        step(40);
        i_module_enable = 1'b0;
        step(2);
        check({o_transmitter_active, o_tx, o_fifo_overrun_flag}, 3'h2);
        close_out();
    end
    initial begin
        step(40000);
        miscompares++;
        close_out();
    end
endmodule
